//--- design/ppmf_pkg.sv
// package of offsets, field positions and reset values for the parity panic mask block
`default_nettype none
package ppmf_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] PPMF_IDX_SW_MASK = 16'hF423;
  localparam logic [15:0] PPMF_IDX_PM_FLAGS = 16'hF470;
  localparam logic [15:0] PPMF_IDX_MEM_MASK = 16'hF424;
  localparam logic [15:0] PPMF_IDX_INT_STATUS = 16'hF480;
  localparam logic [15:0] PPMF_IDX_INT_CLEAR = 16'hF481;
  localparam logic [15:0] PPMF_IDX_INT_ENABLE = 16'hF482;

  // bit positions inside the memory parity mask register
  localparam int PPMF_BIT_RC0 = 0;
  localparam int PPMF_BIT_RC1 = 1;
  localparam int PPMF_BIT_PM0 = 2;
  localparam int PPMF_BIT_PM1 = 3;
  localparam int PPMF_BIT_DM0_B0 = 4;
  localparam int PPMF_BIT_DM0_B1 = 5;
  // software error source in the event vector
  localparam int PPMF_BIT_SW = 6;
  localparam int PPMF_NUM_SRC = 7;
  localparam int PPMF_MEM_MASK_W = 6;

  // flag register layout
  localparam int PPMF_FLAG_B0_SUB5 = 5;
  localparam int PPMF_FLAG_B1_LO = 8;
  localparam int PPMF_NUM_SUB = 6;

  // values after reset
  localparam logic [5:0] PPMF_MEM_MASK_RESET = 6'h03;
  localparam logic PPMF_SW_MASK_RESET = 1'b0;
  localparam logic [6:0] PPMF_INT_ENABLE_RESET = 7'h00;

  // bus answers
  localparam logic [1:0] PPMF_RESP_OKAY = 2'b00;
  localparam logic [1:0] PPMF_RESP_SLVERR = 2'b10;

  // register select produced by the address decoder
  typedef enum {
    PPMF_SEL_NONE,
    PPMF_SEL_SW_MASK,
    PPMF_SEL_PM_FLAGS,
    PPMF_SEL_MEM_MASK,
    PPMF_SEL_INT_STATUS,
    PPMF_SEL_INT_CLEAR,
    PPMF_SEL_INT_ENABLE
  } ppmf_sel_t;

endpackage
`default_nettype wire

//--- design/ppmf_sticky.sv
// sticky flag vector where a set in the clear cycle wins
`default_nettype none
module ppmf_sticky #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);

  // set after clear, so a simultaneous event is kept
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flags <= '0;
    else
      flags <= (flags & ~clr) | set;
  end

endmodule
`default_nettype wire

//--- design/ppmf_top.sv
// parity panic mask registers, program memory parity flags and interrupt
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none

module ppmf_top
  import ppmf_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // parity error pulses from the checkers, same clock
  input wire logic [5:0] pm_bank1_parity_err,
  input wire logic pm_bank0_sub5_parity_err,
  input wire logic dm0_bank0_parity_err,
  input wire logic dm0_bank1_parity_err,
  input wire logic rate_conv0_parity_err,
  input wire logic rate_conv1_parity_err,
  input wire logic software_err,
  // report toward the panic manager
  output logic panic_report,
  output logic [6:0] panic_source,
  output logic irq
);

  // address decode shared by read and write paths
  function automatic ppmf_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[17:2];
    if (addr[1:0] != 2'b00)
      decode = PPMF_SEL_NONE;
    else if (idx == PPMF_IDX_SW_MASK)
      decode = PPMF_SEL_SW_MASK;
    else if (idx == PPMF_IDX_PM_FLAGS)
      decode = PPMF_SEL_PM_FLAGS;
    else if (idx == PPMF_IDX_MEM_MASK)
      decode = PPMF_SEL_MEM_MASK;
    else if (idx == PPMF_IDX_INT_STATUS)
      decode = PPMF_SEL_INT_STATUS;
    else if (idx == PPMF_IDX_INT_CLEAR)
      decode = PPMF_SEL_INT_CLEAR;
    else if (idx == PPMF_IDX_INT_ENABLE)
      decode = PPMF_SEL_INT_ENABLE;
    else
      decode = PPMF_SEL_NONE;
  endfunction

  // software visible state
  logic [5:0] mem_mask;
  logic software_error_mask;
  logic [6:0] int_enable;
  logic [6:0] int_status;
  logic [15:0] program_mem_parity_flags;

  // held write address and data, either may arrive first
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [15:0] w_data;
  logic w_strb;

  // write handshake terms
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire b_done = s_axi_bvalid && s_axi_bready;
  // select held in a variable, enum is two-state and cannot be a net
  ppmf_sel_t wr_sel;
  assign wr_sel = decode(aw_addr);
  wire lo_en = w_strb;

  // write strobes per register
  wire wr_mem_mask = wr_fire && (wr_sel == PPMF_SEL_MEM_MASK) && lo_en;
  wire wr_sw_mask = wr_fire && (wr_sel == PPMF_SEL_SW_MASK) && lo_en;
  wire wr_int_en = wr_fire && (wr_sel == PPMF_SEL_INT_ENABLE) && lo_en;
  wire wr_int_clr = wr_fire && (wr_sel == PPMF_SEL_INT_CLEAR) && lo_en;
  wire wr_bad = (wr_sel == PPMF_SEL_NONE);

  // read handshake terms
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done = s_axi_rvalid && s_axi_rready;
  ppmf_sel_t rd_sel;
  assign rd_sel = decode(s_axi_araddr);

  // error sources lined up with the mask bit positions
  wire [6:0] raw_err;
  assign raw_err[PPMF_BIT_RC0] = rate_conv0_parity_err;
  assign raw_err[PPMF_BIT_RC1] = rate_conv1_parity_err;
  assign raw_err[PPMF_BIT_PM0] = pm_bank0_sub5_parity_err;
  assign raw_err[PPMF_BIT_PM1] = |pm_bank1_parity_err;
  assign raw_err[PPMF_BIT_DM0_B0] = dm0_bank0_parity_err;
  assign raw_err[PPMF_BIT_DM0_B1] = dm0_bank1_parity_err;
  assign raw_err[PPMF_BIT_SW] = software_err;

  // per source suppress selection
  wire [6:0] suppress;
  assign suppress[PPMF_BIT_DM0_B1] = mem_mask[PPMF_BIT_DM0_B1];
  assign suppress[PPMF_BIT_DM0_B0] = mem_mask[PPMF_BIT_DM0_B0];
  assign suppress[PPMF_BIT_PM1] = mem_mask[PPMF_BIT_PM1];
  assign suppress[PPMF_BIT_PM0] = mem_mask[PPMF_BIT_PM0];
  assign suppress[PPMF_BIT_RC1] = mem_mask[PPMF_BIT_RC1];
  assign suppress[PPMF_BIT_RC0] = mem_mask[PPMF_BIT_RC0];
  assign suppress[PPMF_BIT_SW] = software_error_mask;

  wire [6:0] report = raw_err & ~suppress;

  // flag set vector, masked errors still flag
  wire [15:0] flag_set;
  assign flag_set[15:14] = 2'b00;
  assign flag_set[7:6] = 2'b00;
  assign flag_set[4:0] = 5'b0_0000;
  assign flag_set[PPMF_FLAG_B0_SUB5] = pm_bank0_sub5_parity_err;
  genvar g;
  generate
    for (g = 0; g < PPMF_NUM_SUB; g++)
    begin : g_b1_flag
      assign flag_set[PPMF_FLAG_B1_LO + g] = pm_bank1_parity_err[g];
    end
  endgenerate

  // read only flags, no software clear
  ppmf_sticky #(
    .W(16)
  ) u_flags (
    .clk(clk),
    .resetn(resetn),
    .set(flag_set),
    .clr(16'h0000),
    .flags(program_mem_parity_flags)
  );

  // interrupt status, write one to clear, event wins
  wire [6:0] int_clr = wr_int_clr ? w_data[6:0] : 7'h00;
  ppmf_sticky #(
    .W(PPMF_NUM_SRC)
  ) u_int_status (
    .clk(clk),
    .resetn(resetn),
    .set(report),
    .clr(int_clr),
    .flags(int_status)
  );

  // read data selection
  wire [15:0] rd_val =
    (rd_sel == PPMF_SEL_SW_MASK) ? {15'h0000, software_error_mask} :
    (rd_sel == PPMF_SEL_PM_FLAGS) ? program_mem_parity_flags :
    (rd_sel == PPMF_SEL_MEM_MASK) ? {10'h000, mem_mask} :
    (rd_sel == PPMF_SEL_INT_STATUS) ? {9'h000, int_status} :
    (rd_sel == PPMF_SEL_INT_ENABLE) ? {9'h000, int_enable} :
    16'h0000;
  wire rd_bad = (rd_sel == PPMF_SEL_NONE);

  // write address channel capture
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (aw_take)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  // write data channel capture
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      w_held <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 1'b0;
    end
    else if (w_take)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata[15:0];
      w_strb <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  // channel ready flags, low while a word is held
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !(aw_held || aw_take) || (wr_fire && !aw_take);
      s_axi_wready <= !(w_held || w_take) || (wr_fire && !w_take);
    end
  end

  // write response
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PPMF_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? PPMF_RESP_SLVERR : PPMF_RESP_OKAY;
    end
    else if (b_done)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mem_mask <= PPMF_MEM_MASK_RESET;
    else if (wr_mem_mask)
      mem_mask <= w_data[PPMF_MEM_MASK_W-1:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      software_error_mask <= PPMF_SW_MASK_RESET;
    else if (wr_sw_mask)
      software_error_mask <= w_data[0];
  end

  // interrupt enable register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_enable <= PPMF_INT_ENABLE_RESET;
    else if (wr_int_en)
      int_enable <= w_data[6:0];
  end

  // read address ready, one read at a time
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !(s_axi_rvalid || ar_take) || (r_done && !ar_take);
  end

  // read data registered one cycle after the address
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PPMF_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= rd_bad ? PPMF_RESP_SLVERR : PPMF_RESP_OKAY;
    end
    else if (r_done)
      s_axi_rvalid <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      panic_report <= 1'b0;
      panic_source <= 7'h00;
    end
    else
    begin
      panic_report <= |report;
      panic_source <= report;
    end
  end

  // level interrupt from enabled status bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |((int_status & ~int_clr | report) & int_enable);
  end

endmodule
`default_nettype wire

//--- sim/ppmf_assertions.sv
// checker on the parity panic mask block ports
`default_nettype none
module ppmf_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [5:0] pm_bank1_parity_err,
  input wire logic pm_bank0_sub5_parity_err,
  input wire logic dm0_bank0_parity_err,
  input wire logic dm0_bank1_parity_err,
  input wire logic rate_conv0_parity_err,
  input wire logic rate_conv1_parity_err,
  input wire logic software_err,
  input wire logic panic_report,
  input wire logic [6:0] panic_source
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // a report bit needs its error one cycle earlier
  a_dm0b1_cause: assert property (panic_source[5] |-> $past(dm0_bank1_parity_err))
    else $error("dm0 bank1 report without error");
  a_dm0b0_cause: assert property (panic_source[4] |-> $past(dm0_bank0_parity_err))
    else $error("dm0 bank0 report without error");
  a_pm1_cause: assert property (panic_source[3] |-> $past(|pm_bank1_parity_err))
    else $error("pm1 report without error");
  a_pm0_cause: assert property (panic_source[2] |-> $past(pm_bank0_sub5_parity_err))
    else $error("pm0 report without error");
  a_rc_cause: assert property (panic_source[1:0] == ($past(
    {rate_conv1_parity_err, rate_conv0_parity_err}) & panic_source[1:0]))
    else $error("rate converter report without error");
  a_sw_cause: assert property (panic_source[6] |-> $past(software_err))
    else $error("software report without error");
  a_report_any: assert property (panic_report == (|panic_source))
    else $error("report differs from sources");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped");
  c_report: cover property (panic_report);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind ppmf_top ppmf_assertions u_chk (
  .clk(clk),
  .resetn(resetn),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .pm_bank1_parity_err(pm_bank1_parity_err),
  .pm_bank0_sub5_parity_err(pm_bank0_sub5_parity_err),
  .dm0_bank0_parity_err(dm0_bank0_parity_err),
  .dm0_bank1_parity_err(dm0_bank1_parity_err),
  .rate_conv0_parity_err(rate_conv0_parity_err),
  .rate_conv1_parity_err(rate_conv1_parity_err),
  .software_err(software_err),
  .panic_report(panic_report),
  .panic_source(panic_source)
);
`default_nettype wire

//--- sim/ppmf_top_tb.sv
// self-checking bench for the parity panic mask block
`default_nettype none
module ppmf_top_tb
  import ppmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic resetn = 0;
  logic aw = 0, w = 0, br = 0, ar = 0, rr = 0;
  logic [17:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [3:0] ws = 4'hF;
  int hold = 0;
  logic [6:0] e = '0;
  logic [5:0] b1 = '0;
  logic awr, wr_r, bv, arr, rv, rep, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] src;
  int err_count = 0;
  int compares = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  ppmf_top dut (.clk(clk), .resetn(resetn), .s_axi_awvalid(aw), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(w), .s_axi_wready(wr_r),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .pm_bank1_parity_err(b1), .pm_bank0_sub5_parity_err(e[2]),
    .dm0_bank0_parity_err(e[4]), .dm0_bank1_parity_err(e[5]),
    .rate_conv0_parity_err(e[0]), .rate_conv1_parity_err(e[1]), .software_err(e[6]),
    .panic_report(rep), .panic_source(src), .irq(irq));
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // one write; response accepted once hold cycles have passed
  task automatic wr(input logic [15:0] i, input logic [15:0] d, input logic [1:0] x);
    int n = 0;
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= {16'h0000, d};
    aw <= 1;
    w <= 1;
    br <= (hold == 0);
    do
    begin
      @(posedge clk);
      if (aw && awr) aw <= 0;
      if (w && wr_r) w <= 0;
      if (n == hold) br <= 1;
      n++;
    end while (!(bv && br));
    br <= 0;
    chk("bresp", 32'(x), 32'(bresp));
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] xd, input logic [1:0] x);
    int n = 0;
    @(posedge clk);
    ara <= {i, 2'b00};
    ar <= 1;
    rr <= (hold == 0);
    do
    begin
      @(posedge clk);
      if (ar && arr) ar <= 0;
      if (n == hold) rr <= 1;
      n++;
    end while (!(rv && rr));
    rr <= 0;
    chk("rdata", xd, rdata);
    chk("rresp", 32'(x), 32'(rresp));
  endtask
  // one-cycle error pulse, report seen one edge later
  task automatic fire(input logic [6:0] s, input logic [5:0] b, input logic [6:0] x);
    @(posedge clk);
    e <= s;
    b1 <= b;
    @(posedge clk);
    e <= '0;
    b1 <= '0;
    #1;
    chk("panic_source", 32'(x), 32'(src));
    chk("panic_report", 32'(|x), 32'(rep));
  endtask
  task automatic chk_irq(input logic x);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 32'(x), 32'(irq));
  endtask
  task automatic t_reset();
    rd(PPMF_IDX_SW_MASK, 32'h0000_0000, PPMF_RESP_OKAY);
    rd(PPMF_IDX_MEM_MASK, 32'h0000_0003, PPMF_RESP_OKAY);
    rd(PPMF_IDX_PM_FLAGS, 32'h0000_0000, PPMF_RESP_OKAY);
    fire(7'h03, 6'h00, 7'h00);
  endtask
  task automatic t_flags();
    wr(PPMF_IDX_MEM_MASK, 16'h003F, PPMF_RESP_OKAY);
    fire(7'h04, 6'h21, 7'h00);
    rd(PPMF_IDX_PM_FLAGS, 32'h0000_2120, PPMF_RESP_OKAY);
    fire(7'h00, 6'h1E, 7'h00);
    wr(PPMF_IDX_PM_FLAGS, 16'hFFFF, PPMF_RESP_OKAY);
    rd(PPMF_IDX_PM_FLAGS, 32'h0000_3F20, PPMF_RESP_OKAY);
  endtask
  task automatic t_masks();
    logic [6:0] s;
    wr(PPMF_IDX_MEM_MASK, 16'h0000, PPMF_RESP_OKAY);
    for (int i = 0; i < 7; i++)
    begin
      s = 7'(1 << i);
      fire(s, {5'h00, s[3]}, s);
    end
    wr(PPMF_IDX_MEM_MASK, 16'hFFFF, PPMF_RESP_OKAY);
    rd(PPMF_IDX_MEM_MASK, 32'h0000_003F, PPMF_RESP_OKAY);
    wr(PPMF_IDX_SW_MASK, 16'hFFFF, PPMF_RESP_OKAY);
    rd(PPMF_IDX_SW_MASK, 32'h0000_0001, PPMF_RESP_OKAY);
    fire(7'h77, 6'h3F, 7'h00);
  endtask
  task automatic t_irq();
    wr(PPMF_IDX_SW_MASK, 16'h0000, PPMF_RESP_OKAY);
    rd(PPMF_IDX_INT_STATUS, 32'h0000_007F, PPMF_RESP_OKAY);
    wr(PPMF_IDX_INT_CLEAR, 16'h007F, PPMF_RESP_OKAY);
    rd(PPMF_IDX_INT_STATUS, 32'h0000_0000, PPMF_RESP_OKAY);
    wr(PPMF_IDX_INT_ENABLE, 16'h007F, PPMF_RESP_OKAY);
    chk_irq(1'b0);
    fire(7'h40, 6'h00, 7'h40);
    rd(PPMF_IDX_INT_STATUS, 32'h0000_0040, PPMF_RESP_OKAY);
    chk_irq(1'b1);
    wr(PPMF_IDX_INT_ENABLE, 16'h0000, PPMF_RESP_OKAY);
    chk_irq(1'b0);
    wr(PPMF_IDX_INT_ENABLE, 16'h007F, PPMF_RESP_OKAY);
    chk_irq(1'b1);
    wr(PPMF_IDX_INT_CLEAR, 16'h007F, PPMF_RESP_OKAY);
    chk_irq(1'b0);
    rd(PPMF_IDX_INT_STATUS, 32'h0000_0000, PPMF_RESP_OKAY);
    rd(PPMF_IDX_INT_CLEAR, 32'h0000_0000, PPMF_RESP_OKAY);
    rd(16'h0100, 32'h0000_0000, PPMF_RESP_SLVERR);
    wr(16'h0100, 16'hFFFF, PPMF_RESP_SLVERR);
  endtask
  // slow answer acceptance, then a write with no byte lane enabled
  task automatic t_stall();
    hold = 4;
    wr(PPMF_IDX_INT_ENABLE, 16'h0055, PPMF_RESP_OKAY);
    rd(PPMF_IDX_INT_ENABLE, 32'h0000_0055, PPMF_RESP_OKAY);
    hold = 0;
    ws <= 4'h0;
    wr(PPMF_IDX_INT_ENABLE, 16'h0000, PPMF_RESP_OKAY);
    ws <= 4'hF;
    rd(PPMF_IDX_INT_ENABLE, 32'h0000_0055, PPMF_RESP_OKAY);
  endtask
  // reset in mid run brings the mask and flag registers back
  task automatic t_rerun();
    wr(PPMF_IDX_SW_MASK, 16'h0001, PPMF_RESP_OKAY);
    @(posedge clk);
    resetn <= 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    rd(PPMF_IDX_MEM_MASK, 32'h0000_0003, PPMF_RESP_OKAY);
    rd(PPMF_IDX_SW_MASK, 32'h0000_0000, PPMF_RESP_OKAY);
    rd(PPMF_IDX_PM_FLAGS, 32'h0000_0000, PPMF_RESP_OKAY);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_flags();
    t_masks();
    t_irq();
    t_stall();
    t_rerun();
    complete_run();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
